// ===== hw/pmrc_pkg.sv
package pmrc_pkg;
  // register offsets on the plain port
  localparam logic [7:0] ADDR_POWER_CONTROL  = 8'h87;
  localparam logic [7:0] ADDR_INT_OSC_CTRL   = 8'hb2;
  localparam logic [7:0] ADDR_REGULATOR_CTRL = 8'hc9;
  localparam logic [7:0] ADDR_RESET_SOURCE   = 8'hef;
  localparam logic [7:0] ADDR_SUPPLY_MON     = 8'hff;
  // field positions
  localparam int BIT_IDLE          = 0;
  localparam int BIT_STOP          = 1;
  localparam int BIT_GF_LO         = 2;
  localparam int BIT_GF_HI         = 7;
  localparam int BIT_SUSPEND       = 5;
  localparam int BIT_STOP_OFF      = 0;
  localparam int BIT_PIN_FLAG      = 0;
  localparam int BIT_POWER_ON_FLAG = 1;
  localparam int BIT_MCD_FLAG      = 2;
  localparam int BIT_SW_FLAG       = 4;
  localparam int BIT_MON_EN        = 7;
  localparam int BIT_MON_STAT      = 6;
  // reset values
  localparam logic [7:0] RST_POWER_CONTROL = 8'h00;
  localparam logic [7:0] RST_BYTE          = 8'h00;
  localparam logic [7:0] PORT_LATCH_RESET  = 8'hff;
  localparam logic [15:0] RESET_VECTOR     = 16'h0000;
  localparam int WDT_DIVIDE                = 12;
  // timing
  localparam int CLK_MHZ             = 100;
  localparam int POR_DELAY_US        = 300;
  localparam int POR_DELAY_CYCLES    = POR_DELAY_US * CLK_MHZ;
  localparam int MCD_TIMEOUT_US      = 100;
  localparam int MCD_TIMEOUT_CYCLES  = MCD_TIMEOUT_US * CLK_MHZ;
  localparam int OSC_START_CYCLES    = 4;

  typedef enum logic [4:0] {
    PMRC_RESET   = 5'h01,
    PMRC_RUN     = 5'h02,
    PMRC_IDLE    = 5'h04,
    PMRC_STOP    = 5'h08,
    PMRC_SUSPEND = 5'h10
  } pmrc_state_t;
endpackage

// ===== hw/pmrc_top.sv
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
// Notes on behaviour
// [R1] stop select write enters stop right after the write cycle
// [R2] stop halts internal oscillator, core and digital peripheral clocks; external oscillator untouched
// [R3] stop ends only by reset; restart at address zero
// [R4] enabled missing clock detector resets and ends stop; software disables it first
// [R5] regulator on in stop unless stop-off set; then only pin or power cycle resets
// [R6] suspend bit halts core and fast oscillator; contents kept
// [R7] in suspend only port match and timer 3 on slow or external clock run
// [R8] port match, timer 3 overflow, enabled comparator low or reset ends suspend
// [R9] non-reset wake resumes next instruction; configured interrupt then serviced
// [R10] reset ending suspend restarts at address zero
// [R11] general flags 7:2 read-write; stop and idle read zero; resets zero
// [R12] idle gates only the core clock; peripherals keep clocks
// [R13] reset halts core, loads register reset values, forces ports, disables interrupts and timers
// [R14] reset keeps data memory but the stack pointer is reinitialised
// [R15] port latches 0xff open-drain, weak pull-ups on during and after reset
// [R16] power-on and monitor resets drive reset pin low until reset exits
// [R17] reset exit clears program counter, internal osc, watchdog at clock/12, start zero
// [R18] power-on delay after supply passes threshold before reset release
// [R19] power-on flag set on power-on or monitor reset exit, cleared by others
// [R20] monitor enabled by power-on; its enable survives other resets
// [R21] supply low holds reset with pin low; no power-on delay afterwards
// [R22] software enables monitor, waits, then writes power-on flag to select it
// [R23] enabled interrupt or reset ends idle; interrupt wake clears idle
// [R24] missing clock detector resets when clock still over 100 us
// [R25] wake restarts the oscillator before the core clock is enabled again
module pmrc_top #(
  parameter int POR_CYCLES = pmrc_pkg::POR_DELAY_CYCLES,
  parameter int MCD_CYCLES = pmrc_pkg::MCD_TIMEOUT_CYCLES,
  parameter int OSC_CYCLES = pmrc_pkg::OSC_START_CYCLES
) (
  // clock and reset
  input  wire logic        SYS_CLK_I,
  input  wire logic        RSTN_I,
  // register port
  input  wire logic [7:0]  ADDR_I,
  input  wire logic [7:0]  WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [7:0]  RDATA_O,
  // supply and reset pin
  input  wire logic        POWER_GOOD_I,
  input  wire logic        SUPPLY_ABOVE_I,
  input  wire logic        RST_PIN_N_I,
  output logic             RST_PIN_N_O,
  output logic             RST_PIN_OE_O,
  // clock monitor: level of the watched system clock
  input  wire logic        MON_CLK_LEVEL_I,
  // wake sources
  input  wire logic        PORT_MATCH_I,
  input  wire logic        TIMER3_OVF_I,
  input  wire logic        TIMER3_SLOW_CLK_I,
  input  wire logic        COMP_OUT_I,
  input  wire logic        COMP_WAKE_EN_I,
  input  wire logic        IRQ_PENDING_I,
  // clock and core control
  output logic             INT_OSC_EN_O,
  output logic             CORE_CLK_EN_O,
  output logic             PERIPH_CLK_EN_O,
  output logic             TIMER3_CLK_EN_O,
  output logic             PORT_MATCH_EN_O,
  output logic             REGULATOR_ON_O,
  output logic             SYS_RESET_O,
  output logic             WDT_EN_O,
  output logic             WDT_TICK_O,
  output logic      [15:0] PC_START_O,
  output logic             WAKE_IRQ_O,
  // port defaults
  output logic      [7:0]  PORT_LATCH_O,
  output logic             PORT_OPEN_DRAIN_O,
  output logic             WEAK_PULLUP_EN_O
);
  localparam int PW = $clog2(POR_CYCLES + 1);
  localparam int MW = $clog2(MCD_CYCLES + 1);
  localparam int OW = $clog2(OSC_CYCLES + 1);
  localparam logic [7:0] SYNC_IDLE = 8'h44; // reset pin and comparator rest high

  logic        rst_s1_reg, rst_n;
  logic [7:0]  sync_a_reg, sync_b_reg;
  logic        pg, sup, pin_n, mon_clk, pm_s, t3_s, cmp_s, irq_s;

  // reset release through two flops
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      rst_s1_reg <= 1'b0;
      rst_n      <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= 1'b1;
      rst_n      <= rst_s1_reg;
    end
  end

  // pin synchronisers; only the second stage is read
  always_ff @(posedge SYS_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_a_reg <= SYNC_IDLE;
      sync_b_reg <= SYNC_IDLE;
    end
    else
    begin
      sync_a_reg <= {IRQ_PENDING_I, COMP_OUT_I, TIMER3_OVF_I, PORT_MATCH_I,
                     MON_CLK_LEVEL_I, RST_PIN_N_I, SUPPLY_ABOVE_I, POWER_GOOD_I};
      sync_b_reg <= sync_a_reg;
    end
  end
  assign {irq_s, cmp_s, t3_s, pm_s, mon_clk, pin_n, sup, pg} = sync_b_reg;

  pmrc_pkg::pmrc_state_t state_reg, state_next;
  logic [5:0]   general_flags;
  logic         regulator_stop_off;
  logic         supply_monitor_enable;
  logic         mon_sel_reg;
  logic         mcd_en_reg;
  logic         power_on_flag, pin_flag, mcd_flag, sw_flag;
  logic [PW-1:0] por_cnt_reg;
  logic [MW-1:0] mcd_cnt_reg;
  logic [OW-1:0] osc_cnt_reg;
  logic [3:0]   wdt_div_reg;
  logic         mon_last_reg;
  logic         por_hold, mon_low, mcd_fire, sw_fire, rst_req;
  logic         wake_sus, osc_ready, in_reset, reg_dead;
  logic         wr_pc, wr_osc, wr_reg, wr_src, wr_mon;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  assign wr_pc  = WR_I && hit(ADDR_I, pmrc_pkg::ADDR_POWER_CONTROL);
  assign wr_osc = WR_I && hit(ADDR_I, pmrc_pkg::ADDR_INT_OSC_CTRL);
  assign wr_reg = WR_I && hit(ADDR_I, pmrc_pkg::ADDR_REGULATOR_CTRL);
  assign wr_src = WR_I && hit(ADDR_I, pmrc_pkg::ADDR_RESET_SOURCE);
  assign wr_mon = WR_I && hit(ADDR_I, pmrc_pkg::ADDR_SUPPLY_MON);

  // a regulator shut down in stop leaves only the pin and power-good alive
  assign reg_dead = (state_reg == pmrc_pkg::PMRC_STOP) && regulator_stop_off;               // [R5]
  assign mon_low  = supply_monitor_enable && mon_sel_reg && !sup && !reg_dead;               // [R21]
  assign mcd_fire = mcd_en_reg && (mcd_cnt_reg >= MW'(MCD_CYCLES)) && !reg_dead;            // [R24] [R4]
  assign sw_fire  = wr_src && WDATA_I[pmrc_pkg::BIT_SW_FLAG];
  assign por_hold = !pg || (por_cnt_reg != '0);                                              // [R18]
  assign rst_req  = por_hold || mon_low || !pin_n || mcd_fire || sw_fire;                    // [R3] [R10]
  assign in_reset = state_reg == pmrc_pkg::PMRC_RESET;

  // power-on delay: runs only after power-good, never after a monitor drop
  always_ff @(posedge SYS_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
      por_cnt_reg <= PW'(POR_CYCLES);
    else if (!pg)
      por_cnt_reg <= PW'(POR_CYCLES);
    else if (por_cnt_reg != '0)
      por_cnt_reg <= por_cnt_reg - PW'(1);                                                   // [R18]
  end

  // missing clock detector: counts cycles with the watched clock at one level
  always_ff @(posedge SYS_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mcd_cnt_reg  <= '0;
      mon_last_reg <= 1'b0;
    end
    else
    begin
      mon_last_reg <= mon_clk;
      if (in_reset || mon_clk != mon_last_reg)
        mcd_cnt_reg <= '0;
      else if (mcd_cnt_reg < MW'(MCD_CYCLES))
        mcd_cnt_reg <= mcd_cnt_reg + MW'(1);                                                 // [R24]
    end
  end

  // oscillator restart counter; core clock waits for it
  assign osc_ready = osc_cnt_reg == '0;
  always_ff @(posedge SYS_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
      osc_cnt_reg <= OW'(OSC_CYCLES);
    else if (state_reg == pmrc_pkg::PMRC_STOP || state_reg == pmrc_pkg::PMRC_SUSPEND || in_reset)
      osc_cnt_reg <= OW'(OSC_CYCLES);
    else if (!osc_ready)
      osc_cnt_reg <= osc_cnt_reg - OW'(1);                                                   // [R25]
  end

  assign wake_sus = pm_s || t3_s || (COMP_WAKE_EN_I && !cmp_s);                              // [R8]

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      pmrc_pkg::PMRC_RESET:   if (!rst_req) state_next = pmrc_pkg::PMRC_RUN;                // [R17]
      pmrc_pkg::PMRC_RUN:
        if (rst_req)
          state_next = pmrc_pkg::PMRC_RESET;
        else if (wr_pc && WDATA_I[pmrc_pkg::BIT_STOP])
          state_next = pmrc_pkg::PMRC_STOP;                                                  // [R1]
        else if (wr_pc && WDATA_I[pmrc_pkg::BIT_IDLE])
          state_next = pmrc_pkg::PMRC_IDLE;                                                  // [R12]
        else if (wr_osc && WDATA_I[pmrc_pkg::BIT_SUSPEND])
          state_next = pmrc_pkg::PMRC_SUSPEND;                                               // [R6]
      pmrc_pkg::PMRC_IDLE:
        if (rst_req)
          state_next = pmrc_pkg::PMRC_RESET;
        else if (irq_s)
          state_next = pmrc_pkg::PMRC_RUN;                                                   // [R23]
      pmrc_pkg::PMRC_STOP:
        if (rst_req)
          state_next = pmrc_pkg::PMRC_RESET;                                                 // [R3]
      pmrc_pkg::PMRC_SUSPEND:
        if (rst_req)
          state_next = pmrc_pkg::PMRC_RESET;                                                 // [R10]
        else if (wake_sus)
          state_next = pmrc_pkg::PMRC_RUN;                                                   // [R9]
      default: state_next = pmrc_pkg::PMRC_RESET;
    endcase
  end

  always_ff @(posedge SYS_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= pmrc_pkg::PMRC_RESET;
    else
      state_reg <= state_next;
  end

  // power control flags: plain storage, reset in any reset state
  always_ff @(posedge SYS_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
      general_flags <= pmrc_pkg::RST_POWER_CONTROL[pmrc_pkg::BIT_GF_HI:pmrc_pkg::BIT_GF_LO];
    else if (in_reset)
      general_flags <= pmrc_pkg::RST_POWER_CONTROL[pmrc_pkg::BIT_GF_HI:pmrc_pkg::BIT_GF_LO]; // [R11] [R13]
    else if (wr_pc)
      general_flags <= WDATA_I[pmrc_pkg::BIT_GF_HI:pmrc_pkg::BIT_GF_LO];                    // [R11]
  end

  always_ff @(posedge SYS_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
      regulator_stop_off <= 1'b0;
    else if (in_reset)
      regulator_stop_off <= 1'b0;
    else if (wr_reg)
      regulator_stop_off <= WDATA_I[pmrc_pkg::BIT_STOP_OFF];                                 // [R5]
  end

  // monitor enable is only forced on by power-on; other resets leave it
  always_ff @(posedge SYS_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
      supply_monitor_enable <= 1'b1;
    else if (!pg)
      supply_monitor_enable <= 1'b1;                                                         // [R20]
    else if (wr_mon)
      supply_monitor_enable <= WDATA_I[pmrc_pkg::BIT_MON_EN];
  end

  // monitor as reset source; software enables monitor before selecting it
  always_ff @(posedge SYS_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
      mon_sel_reg <= 1'b1;
    else if (!pg)
      mon_sel_reg <= 1'b1;
    else if (wr_src)
      mon_sel_reg <= WDATA_I[pmrc_pkg::BIT_POWER_ON_FLAG];                                   // [R22]
  end

  always_ff @(posedge SYS_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
      mcd_en_reg <= 1'b0;
    else if (in_reset)
      mcd_en_reg <= 1'b0;
    else if (wr_src)
      mcd_en_reg <= WDATA_I[pmrc_pkg::BIT_MCD_FLAG];                                         // [R4]
  end

  // source flags are latched when a reset request arrives outside reset and hold once released
  always_ff @(posedge SYS_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      power_on_flag <= 1'b1;
      pin_flag      <= 1'b0;
      mcd_flag      <= 1'b0;
      sw_flag       <= 1'b0;
    end
    else if (rst_req && !in_reset)
    begin
      power_on_flag <= por_hold || mon_low;                                                  // [R19]
      pin_flag      <= !pin_n;
      mcd_flag      <= mcd_fire;
      sw_flag       <= sw_fire;
    end
    else if (in_reset && (por_hold || mon_low))
      power_on_flag <= 1'b1;                                                                 // [R19]
  end

  // read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge SYS_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
      RDATA_O <= pmrc_pkg::RST_BYTE;
    else if (RD_I)
    begin
      RDATA_O <= pmrc_pkg::RST_BYTE;
      case (ADDR_I)
        pmrc_pkg::ADDR_POWER_CONTROL:
          RDATA_O[pmrc_pkg::BIT_GF_HI:pmrc_pkg::BIT_GF_LO] <= general_flags;               // [R11]
        pmrc_pkg::ADDR_REGULATOR_CTRL:
          RDATA_O[pmrc_pkg::BIT_STOP_OFF] <= regulator_stop_off;
        pmrc_pkg::ADDR_RESET_SOURCE:
        begin
          RDATA_O[pmrc_pkg::BIT_PIN_FLAG]      <= pin_flag;
          RDATA_O[pmrc_pkg::BIT_POWER_ON_FLAG] <= power_on_flag;
          RDATA_O[pmrc_pkg::BIT_MCD_FLAG]      <= mcd_flag || mcd_en_reg;
          RDATA_O[pmrc_pkg::BIT_SW_FLAG]       <= sw_flag;
        end
        pmrc_pkg::ADDR_SUPPLY_MON:
        begin
          RDATA_O[pmrc_pkg::BIT_MON_EN]   <= supply_monitor_enable;
          RDATA_O[pmrc_pkg::BIT_MON_STAT] <= sup;
        end
        default: RDATA_O <= pmrc_pkg::RST_BYTE;
      endcase
    end
  end

  // watchdog tick at system clock / 12
  always_ff @(posedge SYS_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wdt_div_reg <= 4'h0;
      WDT_TICK_O  <= 1'b0;
    end
    else if (in_reset || wdt_div_reg == 4'(pmrc_pkg::WDT_DIVIDE - 1))
    begin
      wdt_div_reg <= 4'h0;
      WDT_TICK_O  <= !in_reset && WDT_EN_O;                                                  // [R17]
    end
    else
    begin
      wdt_div_reg <= wdt_div_reg + 4'h1;
      WDT_TICK_O  <= 1'b0;
    end
  end

  // registered control outputs
  always_ff @(posedge SYS_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      SYS_RESET_O       <= 1'b1;
      RST_PIN_N_O       <= 1'b0;
      RST_PIN_OE_O      <= 1'b1;
      INT_OSC_EN_O      <= 1'b1;
      CORE_CLK_EN_O     <= 1'b0;
      PERIPH_CLK_EN_O   <= 1'b0;
      TIMER3_CLK_EN_O   <= 1'b0;
      PORT_MATCH_EN_O   <= 1'b0;
      REGULATOR_ON_O    <= 1'b1;
      WDT_EN_O          <= 1'b0;
      PC_START_O        <= pmrc_pkg::RESET_VECTOR;
      WAKE_IRQ_O        <= 1'b0;
      PORT_LATCH_O      <= pmrc_pkg::PORT_LATCH_RESET;
      PORT_OPEN_DRAIN_O <= 1'b1;
      WEAK_PULLUP_EN_O  <= 1'b1;
    end
    else
    begin
      SYS_RESET_O      <= state_next == pmrc_pkg::PMRC_RESET;                               // [R13] [R14]
      RST_PIN_N_O      <= 1'b0;
      RST_PIN_OE_O     <= state_next == pmrc_pkg::PMRC_RESET && (por_hold || mon_low);       // [R16] [R21]
      INT_OSC_EN_O     <= state_next != pmrc_pkg::PMRC_STOP && state_next != pmrc_pkg::PMRC_SUSPEND; // [R2] [R6]
      CORE_CLK_EN_O    <= state_next == pmrc_pkg::PMRC_RUN && osc_ready;                     // [R12] [R25]
      PERIPH_CLK_EN_O  <= (state_next == pmrc_pkg::PMRC_RUN || state_next == pmrc_pkg::PMRC_IDLE)
                          && osc_ready;                                                      // [R2] [R12]
      TIMER3_CLK_EN_O  <= state_next != pmrc_pkg::PMRC_RESET && state_next != pmrc_pkg::PMRC_STOP
                          && (state_next != pmrc_pkg::PMRC_SUSPEND || TIMER3_SLOW_CLK_I);    // [R7]
      PORT_MATCH_EN_O  <= state_next != pmrc_pkg::PMRC_RESET && state_next != pmrc_pkg::PMRC_STOP; // [R7]
      REGULATOR_ON_O   <= !(state_next == pmrc_pkg::PMRC_STOP && regulator_stop_off);        // [R5]
      WDT_EN_O         <= WDT_EN_O || in_reset;                                              // [R17]
      PC_START_O       <= pmrc_pkg::RESET_VECTOR;                                            // [R17]
      // pulse tells the core to service the wake interrupt on resume
      WAKE_IRQ_O       <= state_reg == pmrc_pkg::PMRC_SUSPEND && state_next == pmrc_pkg::PMRC_RUN
                          && (pm_s || t3_s);                                                 // [R9]
      PORT_LATCH_O     <= pmrc_pkg::PORT_LATCH_RESET;                                        // [R15]
      PORT_OPEN_DRAIN_O <= 1'b1;                                                             // [R15]
      WEAK_PULLUP_EN_O <= 1'b1;                                                              // [R15]
    end
  end
endmodule

// ===== verification/pmrc_chk.sv
`timescale 1ns/1ps
module pmrc_chk (
  // watched ports
  input wire logic        SYS_CLK_I,
  input wire logic        RSTN_I,
  input wire logic [7:0]  ADDR_I,
  input wire logic [7:0]  WDATA_I,
  input wire logic        WR_I,
  input wire logic        RD_I,
  input wire logic        IRQ_PENDING_I,
  input wire logic [7:0]  RDATA_O,
  input wire logic        INT_OSC_EN_O,
  input wire logic        CORE_CLK_EN_O,
  input wire logic        PERIPH_CLK_EN_O,
  input wire logic        PORT_MATCH_EN_O,
  input wire logic        SYS_RESET_O,
  input wire logic        WDT_TICK_O,
  input wire logic        WAKE_IRQ_O,
  input wire logic [15:0] PC_START_O,
  input wire logic [7:0]  PORT_LATCH_O,
  input wire logic        PORT_OPEN_DRAIN_O,
  input wire logic        WEAK_PULLUP_EN_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RSTN_I);
  logic pc_wr;
  assign pc_wr = WR_I && ADDR_I == 8'h87 && CORE_CLK_EN_O;
  a_port_defaults: assert property (PORT_LATCH_O == 8'hff && PORT_OPEN_DRAIN_O && WEAK_PULLUP_EN_O)
    else $error("port defaults lost");
  a_start_zero: assert property (PC_START_O == 16'h0000)
    else $error("start address not zero");
  a_stop_enter: assert property (pc_wr && WDATA_I[1] |-> ##[1:2] !(INT_OSC_EN_O || CORE_CLK_EN_O || PERIPH_CLK_EN_O))
    else $error("stop not entered");
  a_stop_hold: assert property (!INT_OSC_EN_O && !PORT_MATCH_EN_O && !SYS_RESET_O |=> !CORE_CLK_EN_O)
    else $error("stop left without reset");
  a_osc_first: assert property ($rose(CORE_CLK_EN_O) && !SYS_RESET_O |-> INT_OSC_EN_O && $past(INT_OSC_EN_O))
    else $error("core clock before oscillator");
  a_read_mask: assert property (RD_I && ADDR_I == 8'h87 |=> RDATA_O[1:0] == 2'b00)
    else $error("mode bits read nonzero");
  a_idle_gate: assert property (pc_wr && WDATA_I[1:0] == 2'b01 && !IRQ_PENDING_I
    |-> ##[1:2] !CORE_CLK_EN_O && PERIPH_CLK_EN_O)
    else $error("idle gating wrong");
  a_wake_resume: assert property ($rose(WAKE_IRQ_O) |-> ##[1:8] CORE_CLK_EN_O)
    else $error("no resume after wake");
  a_wdt_period: assert property (disable iff (!RSTN_I || SYS_RESET_O)
    WDT_TICK_O |=> !WDT_TICK_O [*8] ##4 WDT_TICK_O)
    else $error("watchdog tick period wrong");
  c_stop: cover property (pc_wr && WDATA_I[1]);
  c_wake: cover property ($rose(WAKE_IRQ_O));
  c_idle: cover property (pc_wr && WDATA_I[1:0] == 2'b01);
endmodule
bind pmrc_top pmrc_chk i_chk (
  .SYS_CLK_I(SYS_CLK_I), .RSTN_I(RSTN_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
  .IRQ_PENDING_I(IRQ_PENDING_I), .RDATA_O(RDATA_O), .INT_OSC_EN_O(INT_OSC_EN_O), .CORE_CLK_EN_O(CORE_CLK_EN_O),
  .PERIPH_CLK_EN_O(PERIPH_CLK_EN_O), .PORT_MATCH_EN_O(PORT_MATCH_EN_O), .SYS_RESET_O(SYS_RESET_O),
  .WDT_TICK_O(WDT_TICK_O), .WAKE_IRQ_O(WAKE_IRQ_O), .PC_START_O(PC_START_O), .PORT_LATCH_O(PORT_LATCH_O),
  .PORT_OPEN_DRAIN_O(PORT_OPEN_DRAIN_O), .WEAK_PULLUP_EN_O(WEAK_PULLUP_EN_O));

// ===== verification/pmrc_far.sv
`timescale 1ns/1ps
module pmrc_far (
  // bench commands
  input  wire logic       clk_i,
  input  wire logic       pin_req_i,
  input  wire logic       sup_ok_i,
  input  wire logic [3:0] ev_i,
  // device side
  input  wire logic       osc_on_i,
  input  wire logic       pin_oe_i,
  input  wire logic       pin_lvl_i,
  output logic            power_good_o,
  output logic            supply_above_o,
  output logic            pin_n_o,
  output logic            mon_clk_o,
  output logic [3:0]      wake_o
);
  logic [3:0] ramp = 4'h0;
  initial mon_clk_o = 1'b0;
  always @(posedge clk_i)
    if (ramp != 4'hf)
      ramp <= ramp + 4'h1;
  assign power_good_o   = ramp == 4'hf;
  assign supply_above_o = sup_ok_i && power_good_o;
  // pin has a pull-up; a button or the device may pull it low
  assign pin_n_o = (pin_oe_i ? pin_lvl_i : 1'b1) && !pin_req_i;
  // watched clock stands still once the oscillator halts
  always @(posedge clk_i)
    mon_clk_o <= osc_on_i ? !mon_clk_o : mon_clk_o;
  // comparator wakes on a low output
  assign wake_o = {ev_i[3], !ev_i[2], ev_i[1:0]};
endmodule

// ===== verification/pmrc_top_tb.sv
`timescale 1ns/1ps
module pmrc_top_tb;
  logic        clk = 1'b0, rstn = 1'b0, wr_s = 1'b0, rd_s = 1'b0, rd_d = 1'b0;
  logic        pin_req = 1'b0, sup_ok = 1'b1, t3slow = 1'b1, cmp_en = 1'b1, reg_on, wdt_en;
  logic [3:0]  ev = 4'h0, wk;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, latch, gf;
  logic [15:0] pc;
  logic        pg, sup, pin_n, mclk, pin_o, pin_oe, osc, core, peri, t3en, pmen, sres, od, pu;
  logic [7:0]  exp_q[$], msk_q[$];
  int          miscompares = 0, n_tests = 0, cyc = 0;
  always #5 clk = ~clk;
  pmrc_top #(.POR_CYCLES(20), .MCD_CYCLES(16), .OSC_CYCLES(4)) i_dut (
    .SYS_CLK_I(clk), .RSTN_I(rstn), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata),
    .POWER_GOOD_I(pg), .SUPPLY_ABOVE_I(sup), .RST_PIN_N_I(pin_n), .RST_PIN_N_O(pin_o), .RST_PIN_OE_O(pin_oe),
    .MON_CLK_LEVEL_I(mclk), .PORT_MATCH_I(wk[0]), .TIMER3_OVF_I(wk[1]), .TIMER3_SLOW_CLK_I(t3slow),
    .COMP_OUT_I(wk[2]), .COMP_WAKE_EN_I(cmp_en), .IRQ_PENDING_I(wk[3]), .INT_OSC_EN_O(osc), .CORE_CLK_EN_O(core),
    .PERIPH_CLK_EN_O(peri), .TIMER3_CLK_EN_O(t3en), .PORT_MATCH_EN_O(pmen), .REGULATOR_ON_O(reg_on),
    .SYS_RESET_O(sres), .WDT_EN_O(wdt_en), .WDT_TICK_O(), .PC_START_O(pc), .WAKE_IRQ_O(), .PORT_LATCH_O(latch),
    .PORT_OPEN_DRAIN_O(od),
    .WEAK_PULLUP_EN_O(pu));
  pmrc_far i_far (.clk_i(clk), .pin_req_i(pin_req), .sup_ok_i(sup_ok), .ev_i(ev), .osc_on_i(osc),
    .pin_oe_i(pin_oe), .pin_lvl_i(pin_o), .power_good_o(pg), .supply_above_o(sup), .pin_n_o(pin_n),
    .mon_clk_o(mclk), .wake_o(wk));
  task check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task reg_rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk);
    exp_q.push_back(e);
    msk_q.push_back(m);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
  endtask
  // k=1 waits for the reset state, k=0 for a running core
  task wt(input int k);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (!(k ? sres === 1'b1 : (core === 1'b1 && sres === 1'b0)) && n < 400);
    check(16'(n < 400), 16'h0001, "wait");
  endtask
  always @(posedge clk)
  begin
    rd_d <= rd_s;
    cyc <= cyc + 1;
    if (rd_d)
      check(16'(rdata & msk_q.pop_front()), 16'(exp_q.pop_front()), "rdata");
    if (cyc == 5000)
    begin
      miscompares++;
      finish_test;
    end
  end
  initial
  begin
    void'($urandom(32'h3c29));
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    wt(0);
    reg_rd(8'hef, 8'h02, 8'h02);
    reg_rd(8'hff, 8'h80, 8'h80);
    reg_rd(8'h87, 8'h00, 8'hff);
    reg_rd(8'h10, 8'h00, 8'hff);
    check(pc, 16'h0000, "start");
    check({latch, od, pu}, 16'h03ff, "ports");
    repeat (4)
    begin
      gf = 8'($urandom) & 8'hfc;
      reg_wr(8'h87, gf | 8'h02 & 8'h00);
      reg_rd(8'h87, gf, 8'hff);
    end
    reg_wr(8'h87, gf | 8'h01);
    repeat (3) @(posedge clk);
    check({core, peri}, 16'h0001, "idle");
    ev[3] <= 1'b1;
    wt(0);
    ev[3] <= 1'b0;
    reg_rd(8'h87, gf, 8'hff);
    $display("idle test done");
    for (int k = 0; k < 3; k++)
    begin
      // a disabled comparator held low must not wake; timer 3 runs only when slow-clocked
      t3slow <= k != 0;
      cmp_en <= k == 2;
      ev[2]  <= k != 2;
      reg_wr(8'hb2, 8'h20);
      repeat (8) @(posedge clk);
      check({osc, core, pmen, t3en}, {14'h0000, 1'b1, k != 0}, "suspend");
      ev[k] <= 1'b1;
      wt(0);
      ev[k] <= 1'b0;
      reg_rd(8'h87, gf, 8'hff);
    end
    $display("suspend test done");
    reg_wr(8'hef, 8'h02);
    reg_wr(8'h87, 8'h02);
    repeat (40) @(posedge clk);
    check({osc, core, peri, sres}, 16'h0000, "stop");
    pin_req <= 1'b1;
    wt(1);
    check(pin_oe, 16'h0000, "pin drive");
    pin_req <= 1'b0;
    wt(0);
    reg_rd(8'hef, 8'h01, 8'h03);
    reg_rd(8'h87, 8'h00, 8'hff);
    reg_rd(8'hff, 8'h80, 8'h80);
    reg_wr(8'hef, 8'h06);
    reg_wr(8'h87, 8'h02);
    wt(1);
    wt(0);
    reg_rd(8'hef, 8'h04, 8'h07);
    $display("stop test done");
    sup_ok <= 1'b0;
    wt(1);
    repeat (3) @(posedge clk);
    check({sres, pin_oe}, 16'h0003, "supply low");
    sup_ok <= 1'b1;
    wt(0);
    reg_rd(8'hef, 8'h02, 8'h02);
    reg_wr(8'hff, 8'h00);
    reg_wr(8'hef, 8'h10);
    wt(1);
    wt(0);
    reg_rd(8'hff, 8'h00, 8'h80);
    reg_rd(8'hef, 8'h10, 8'h12);
    reg_wr(8'hff, 8'h80);
    repeat (10) @(posedge clk);
    reg_wr(8'hef, 8'h02);
    reg_rd(8'hff, 8'h80, 8'h80);
    repeat (3) @(posedge clk);
    $display("supply test done");
    reg_wr(8'hc9, 8'h01);
    reg_rd(8'hc9, 8'h01, 8'h01);
    reg_wr(8'hef, 8'h06);
    reg_wr(8'h87, 8'h02);
    repeat (40) @(posedge clk);
    check({sres, reg_on, wdt_en}, 16'h0001, "regulator off");
    pin_req <= 1'b1;
    wt(1);
    pin_req <= 1'b0;
    wt(0);
    check({reg_on, wdt_en}, 16'h0003, "regulator on");
    reg_rd(8'hc9, 8'h00, 8'h01);
    reg_rd(8'hef, 8'h01, 8'h07);
    repeat (3) @(posedge clk);
    $display("regulator test done");
    finish_test;
  end
endmodule
